// ---- design/dmd_pkg.sv ----
/*
 * Constants and types of the data space decoder.
 * Assumes one 100 MHz CPU clock.
 */
package dmd_pkg;

  // ----------------------------------------------------------------
  // Data space map
  // ----------------------------------------------------------------
  localparam logic [15:0] RF_LAST       = 16'h001F;
  localparam logic [15:0] IO_FIRST      = 16'h0020;
  localparam logic [15:0] IO_LAST       = 16'h005F;
  localparam logic [15:0] XIO_FIRST     = 16'h0060;
  localparam logic [15:0] XIO_LAST      = 16'h00FF;
  localparam logic [15:0] SRAM_FIRST    = 16'h0100;
  localparam logic [15:0] SRAM_LAST     = 16'h40FF;
  localparam int          RF_DEPTH      = 32;
  localparam int          SRAM_DEPTH    = 16384;
  localparam int          SRAM_AW       = 14;
  localparam logic [7:0]  IO_SHORT_BASE = 8'h20;

  // Pointer pairs in the register file, low byte index
  localparam logic [4:0]  PTR_X_LO      = 5'h1A;
  localparam logic [4:0]  PTR_Y_LO      = 5'h1C;
  localparam logic [4:0]  PTR_Z_LO      = 5'h1E;

  // ----------------------------------------------------------------
  // Program memory
  // ----------------------------------------------------------------
  localparam int          PM_DEPTH      = 65536;
  localparam logic [15:0] BOOT_START    = 16'hF000;

  // ----------------------------------------------------------------
  // EEPROM
  // ----------------------------------------------------------------
  localparam int          EE_DEPTH      = 4096;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          EE_WRITE_NS   = 3400000;
  localparam int          EE_WRITE_CYC  = EE_WRITE_NS / CLK_PERIOD_NS;
  localparam int          EE_TMR_W      = 19;
  localparam logic [2:0]  EE_ARM_CYC    = 3'h4;
  localparam logic [2:0]  EE_RD_STALL   = 3'h4;
  localparam logic [2:0]  EE_WR_STALL   = 3'h2;
  localparam logic [7:0]  RESET_BYTE    = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    AM_DIRECT, AM_DISP, AM_INDIRECT, AM_PREDEC, AM_POSTINC, AM_IO_SHORT
  } dmd_mode_t;

  typedef enum logic [1:0] { PS_X, PS_Y, PS_Z } dmd_ptr_t;

  typedef enum logic [2:0] { RG_RF, RG_IO, RG_XIO, RG_SRAM, RG_NONE } dmd_region_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    dmd_mode_t  mode;
    dmd_ptr_t   ptr;
    logic [15:0] addr;
    logic [5:0] disp;
    logic [7:0] wdata;
  } dmd_req_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dmd_io_t;

endpackage

// ---- design/dmd_countdown.sv ----
/*
 * Loadable down counter with busy flag and done pulse.
 * Assumes loads of one or more; a load while busy restarts it.
 */
`timescale 1ns/1ps
module dmd_countdown #(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  // Status
  output logic              busy,
  output logic              done
);

  logic [W-1:0] count_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      done      <= 1'b0;
    end else if (load) begin
      count_reg <= value;
      done      <= 1'b0;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
      done      <= (count_reg == W'(1));
    end else begin
      done      <= 1'b0;
    end
  end

  assign busy = (count_reg != '0);

endmodule

// ---- design/dmd_mem_decoder.sv ----
/*
 * Data space decoder, program memory and EEPROM port of the core.
 * Assumes the core on this clock and I/O registers that answer
 * io_rdata combinationally while io_out.valid is high.
 */
`timescale 1ns/1ps
// Behaviour
// - 0000..001F selects the register file.
// - 0020..005F selects standard I/O.
// - 0060..00FF selects extended I/O.
// - 0100..40FF selects the 16K byte SRAM.
// - Short I/O opcode never reaches extended I/O.
// - Direct addressing reaches all data space.
// - Displacement adds up to 63 to Y or Z.
// - R26..R31 are the X, Y and Z pointers.
// - Pre-decrement lowers first; post-increment raises after.
// - SRAM access takes two cycles.
// - Program memory holds 16-bit words; instructions are one or two.
// - 16-bit program counter addresses 64K words.
// - Program memory has boot and application sections.
// - Program memory load reads constants from program memory.
// - 4K EEPROM is a separate byte-wide space.
// - EEPROM read stalls the CPU four cycles.
// - EEPROM write stalls the CPU two cycles.
// - EEPROM writes are self-timed with busy status.
// - A running write survives system reset.
// - Writes need the arming sequence; software must follow it.
// - Strobe must follow arm within four cycles.
// - Arm bit clears four cycles after set.
// - Strobe bit clears when write time elapses.
module dmd_mem_decoder #(
  parameter int EE_WRITE_CYCLES = dmd_pkg::EE_WRITE_CYC
) (
  // Clock and resets
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              por_n,
  // Data access request and answer
  input  wire dmd_pkg::dmd_req_t req,
  output logic                   req_ready,
  output logic                   resp_valid,
  output logic [7:0]             resp_rdata,
  // Register file write port of the core
  input  wire logic              rf_we,
  input  wire logic [4:0]        rf_idx,
  input  wire logic [7:0]        rf_wdata,
  // I/O register port
  output dmd_pkg::dmd_io_t       io_out,
  input  wire logic [7:0]        io_rdata,
  // Instruction fetch
  input  wire logic [15:0]       pc,
  output logic [15:0]            fetch_word,
  output logic                   fetch_in_boot,
  // Program memory load and write
  input  wire logic              pm_load_valid,
  output logic                   pm_load_done,
  output logic [7:0]             pm_load_data,
  input  wire logic              pm_wr_en,
  input  wire logic [15:0]       pm_wr_addr,
  input  wire logic [15:0]       pm_wr_data,
  input  wire logic              pm_wr_from_boot,
  // EEPROM byte interface
  input  wire logic [11:0]       ee_addr,
  input  wire logic [7:0]        ee_wdata,
  input  wire logic              ee_read_trig,
  input  wire logic              ee_arm_set,
  input  wire logic              ee_strobe_set,
  output logic [7:0]             ee_rdata,
  output logic                   eeprom_write_arm,
  output logic                   eeprom_write_strobe,
  output logic                   cpu_stall
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]  rf_mem   [dmd_pkg::RF_DEPTH];
  logic [7:0]  sram_mem [dmd_pkg::SRAM_DEPTH];
  logic [15:0] pm_mem   [dmd_pkg::PM_DEPTH];
  logic [7:0]  ee_mem   [dmd_pkg::EE_DEPTH];

  typedef enum {DS_IDLE, DS_ACCESS} dmd_state_t;
  dmd_state_t  state_reg;

  logic [15:0] addr_reg;
  logic        write_reg;
  logic [7:0]  wdata_reg;
  dmd_pkg::dmd_region_t region_reg;

  // ----------------------------------------------------------------
  // Address formation
  // ----------------------------------------------------------------
  logic [4:0]  ptr_lo;
  logic [4:0]  disp_lo;
  logic [15:0] ptr_val;
  logic [15:0] addr_next;
  logic [15:0] ptr_next;
  logic        ptr_upd;
  dmd_pkg::dmd_region_t region_next;
  logic        take;

  always_comb begin
    case (req.ptr)
      dmd_pkg::PS_X: ptr_lo = dmd_pkg::PTR_X_LO;
      dmd_pkg::PS_Y: ptr_lo = dmd_pkg::PTR_Y_LO;
      default:       ptr_lo = dmd_pkg::PTR_Z_LO;
    endcase
  end

  assign ptr_val = {rf_mem[ptr_lo + 5'h01], rf_mem[ptr_lo]};
  assign disp_lo = (req.ptr == dmd_pkg::PS_Z) ? dmd_pkg::PTR_Z_LO : dmd_pkg::PTR_Y_LO;

  always_comb begin
    ptr_next = ptr_val;
    ptr_upd  = 1'b0;
    case (req.mode)
      dmd_pkg::AM_DIRECT: begin
        addr_next = req.addr;
      end
      dmd_pkg::AM_DISP: begin
        // Only Y or Z carry a displacement
        addr_next = {rf_mem[disp_lo + 5'h01], rf_mem[disp_lo]} + {10'h000, req.disp};
      end
      dmd_pkg::AM_PREDEC: begin
        ptr_next  = ptr_val - 16'h0001;
        addr_next = ptr_next;
        ptr_upd   = 1'b1;
      end
      dmd_pkg::AM_POSTINC: begin
        addr_next = ptr_val;
        ptr_next  = ptr_val + 16'h0001;
        ptr_upd   = 1'b1;
      end
      dmd_pkg::AM_IO_SHORT: begin
        // Six-bit field cannot reach past 005F
        addr_next = {8'h00, dmd_pkg::IO_SHORT_BASE + {2'b00, req.addr[5:0]}};
      end
      default: begin
        addr_next = ptr_val;
      end
    endcase
  end

  always_comb begin
    if (addr_next <= dmd_pkg::RF_LAST) begin
      region_next = dmd_pkg::RG_RF;
    end else if (addr_next <= dmd_pkg::IO_LAST) begin
      region_next = dmd_pkg::RG_IO;
    end else if (addr_next <= dmd_pkg::XIO_LAST) begin
      region_next = dmd_pkg::RG_XIO;
    end else if (addr_next <= dmd_pkg::SRAM_LAST) begin
      region_next = dmd_pkg::RG_SRAM;
    end else begin
      region_next = dmd_pkg::RG_NONE;
    end
  end

  assign take = req.valid && (state_reg == DS_IDLE) && !cpu_stall;

  // ----------------------------------------------------------------
  // Two-cycle access sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg  <= DS_IDLE;
      req_ready  <= 1'b0;
      resp_valid <= 1'b0;
      addr_reg   <= '0;
      write_reg  <= 1'b0;
      wdata_reg  <= dmd_pkg::RESET_BYTE;
      region_reg <= dmd_pkg::RG_NONE;
    end else begin
      resp_valid <= 1'b0;
      case (state_reg)
        DS_IDLE: begin
          req_ready <= !cpu_stall;
          if (take) begin
            state_reg  <= DS_ACCESS;
            req_ready  <= 1'b0;
            addr_reg   <= addr_next;
            write_reg  <= req.write;
            wdata_reg  <= req.wdata;
            region_reg <= region_next;
          end
        end
        default: begin
          state_reg  <= DS_IDLE;
          resp_valid <= 1'b1;
          req_ready  <= 1'b1;
        end
      endcase
    end
  end

  // Both I/O regions leave through io_out
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      io_out <= '0;
    end else begin
      io_out.valid <= take && (region_next == dmd_pkg::RG_IO ||
                               region_next == dmd_pkg::RG_XIO);
      io_out.write <= req.write;
      io_out.addr  <= addr_next[7:0];
      io_out.wdata <= req.wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      resp_rdata <= dmd_pkg::RESET_BYTE;
    end else if (state_reg == DS_ACCESS && !write_reg) begin
      case (region_reg)
        dmd_pkg::RG_RF:   resp_rdata <= rf_mem[addr_reg[4:0]];
        dmd_pkg::RG_IO,
        dmd_pkg::RG_XIO:  resp_rdata <= io_rdata;
        dmd_pkg::RG_SRAM: resp_rdata <= sram_mem[dmd_pkg::SRAM_AW'(addr_reg
                                        - dmd_pkg::SRAM_FIRST)];
        default:          resp_rdata <= dmd_pkg::RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (state_reg == DS_ACCESS && write_reg && region_reg == dmd_pkg::RG_SRAM) begin
      sram_mem[dmd_pkg::SRAM_AW'(addr_reg - dmd_pkg::SRAM_FIRST)] <= wdata_reg;
    end
  end

  // Store, then pointer update, then core write
  always_ff @(posedge clk) begin
    if (state_reg == DS_ACCESS && write_reg && region_reg == dmd_pkg::RG_RF) begin
      rf_mem[addr_reg[4:0]] <= wdata_reg;
    end else if (take && ptr_upd) begin
      rf_mem[ptr_lo]          <= ptr_next[7:0];
      rf_mem[ptr_lo + 5'h01]  <= ptr_next[15:8];
    end else if (rf_we) begin
      rf_mem[rf_idx] <= rf_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Program memory
  // ----------------------------------------------------------------
  logic [15:0] z_ptr;
  logic [15:0] pm_word;

  assign z_ptr   = {rf_mem[dmd_pkg::PTR_Z_LO + 5'h01], rf_mem[dmd_pkg::PTR_Z_LO]};
  assign pm_word = pm_mem[z_ptr[15:1]];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fetch_word    <= '0;
      fetch_in_boot <= 1'b0;
      pm_load_done  <= 1'b0;
      pm_load_data  <= dmd_pkg::RESET_BYTE;
    end else begin
      fetch_word    <= pm_mem[pc];
      fetch_in_boot <= (pc >= dmd_pkg::BOOT_START);
      pm_load_done  <= pm_load_valid;
      if (pm_load_valid) begin
        // Byte address: bit 0 picks the high or low half of the word
        pm_load_data <= z_ptr[0] ? pm_word[15:8] : pm_word[7:0];
      end
    end
  end

  // Application code may not overwrite the boot section
  always_ff @(posedge clk) begin
    if (pm_wr_en && (pm_wr_from_boot || pm_wr_addr < dmd_pkg::BOOT_START)) begin
      pm_mem[pm_wr_addr] <= pm_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // EEPROM arming and write engine
  // ----------------------------------------------------------------
  logic        arm_busy;
  logic        arm_done;
  logic        wr_start;
  logic        wr_done;
  logic        stall_load;
  logic [2:0]  stall_val;
  logic        stall_busy;
  logic [11:0] ee_addr_lat;
  logic [7:0]  ee_data_lat;

  // Strobe needs a live arm and no write already running
  assign wr_start = ee_strobe_set && eeprom_write_arm && !eeprom_write_strobe;

  dmd_countdown #(.W(3)) u_arm (
    .clk   (clk),
    .rst_n (arst_n),
    .load  (ee_arm_set),
    .value (dmd_pkg::EE_ARM_CYC - 3'h1),
    .busy  (arm_busy),
    .done  (arm_done)
  );

  // Set wins over the timeout in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      eeprom_write_arm <= 1'b0;
    end else if (ee_arm_set) begin
      eeprom_write_arm <= 1'b1;
    end else if (arm_done || wr_start) begin
      eeprom_write_arm <= 1'b0;
    end
  end

  // Power-on reset only: system reset must not cut a write short
  dmd_countdown #(.W(dmd_pkg::EE_TMR_W)) u_wtmr (
    .clk   (clk),
    .rst_n (por_n),
    .load  (wr_start),
    .value (dmd_pkg::EE_TMR_W'(EE_WRITE_CYCLES)),
    .busy  (),
    .done  (wr_done)
  );

  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      eeprom_write_strobe <= 1'b0;
      ee_addr_lat         <= '0;
      ee_data_lat         <= dmd_pkg::RESET_BYTE;
    end else if (wr_start) begin
      eeprom_write_strobe <= 1'b1;
      ee_addr_lat         <= ee_addr;
      ee_data_lat         <= ee_wdata;
    end else if (wr_done) begin
      eeprom_write_strobe <= 1'b0;
    end
  end

  // Byte lands when the write time ends
  always_ff @(posedge clk) begin
    if (wr_done) begin
      ee_mem[ee_addr_lat] <= ee_data_lat;
    end
  end

  // Reads ignored while a write runs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ee_rdata <= dmd_pkg::RESET_BYTE;
    end else if (ee_read_trig && !eeprom_write_strobe) begin
      ee_rdata <= ee_mem[ee_addr];
    end
  end

  // ----------------------------------------------------------------
  // CPU stall
  // ----------------------------------------------------------------
  assign stall_load = (ee_read_trig && !eeprom_write_strobe) || wr_start;
  assign stall_val  = (wr_start ? dmd_pkg::EE_WR_STALL : dmd_pkg::EE_RD_STALL) - 3'h1;

  dmd_countdown #(.W(3)) u_stall (
    .clk   (clk),
    .rst_n (arst_n),
    .load  (stall_load),
    .value (stall_val),
    .busy  (stall_busy),
    .done  ()
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_stall <= 1'b0;
    end else begin
      cpu_stall <= stall_load || stall_busy;
    end
  end

endmodule

// ---- dv/dmd_io_regs_model.sv ----
/*
 * I/O register bank model on the far side of the decoder's I/O port.
 * Assumes io_out pulses one cycle; reads answer within that cycle.
 */
`timescale 1ns/1ps
module dmd_io_regs_model (
  // Clock
  input  wire logic             clk,
  // Decoder I/O port
  input  wire dmd_pkg::dmd_io_t io_out,
  output logic [7:0]            io_rdata
);
  // ----------------------------------------------------------------
  // Storage and answer
  // ----------------------------------------------------------------
  logic [7:0] regs [256];
  logic [7:0] last_q = 8'hA5;

  // Outside a read the bus never repeats the byte of the cycle before
  assign io_rdata = (io_out.valid && !io_out.write) ? regs[io_out.addr] : ~last_q;

  always_ff @(posedge clk) begin
    last_q <= io_rdata;
    if (io_out.valid && io_out.write) begin
      regs[io_out.addr] <= io_out.wdata;
    end
  end
endmodule

// ---- dv/dmd_mem_decoder_properties.sv ----
/*
 * Port-level checks of the decoder, bound into every instance.
 * Assumes one clock; strobe length follows EE_WRITE_CYCLES.
 */
`timescale 1ns/1ps
module dmd_mem_decoder_checker #(
  parameter int EE_WRITE_CYCLES = 20
) (
  // Clock and resets
  input wire logic              clk,
  input wire logic              arst_n,
  input wire logic              por_n,
  // Data access
  input wire dmd_pkg::dmd_req_t req,
  input wire logic              req_ready,
  input wire logic              resp_valid,
  input wire dmd_pkg::dmd_io_t  io_out,
  // Fetch
  input wire logic [15:0]       pc,
  input wire logic              fetch_in_boot,
  // EEPROM
  input wire logic              ee_read_trig,
  input wire logic              ee_arm_set,
  input wire logic              ee_strobe_set,
  input wire logic              eeprom_write_arm,
  input wire logic              eeprom_write_strobe,
  input wire logic              cpu_stall
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic        take;
  logic        dir;
  logic [7:0]  short_a;
  logic [19:0] wr_cnt;

  assign take    = req.valid && req_ready && !cpu_stall;
  assign dir     = take && req.mode == dmd_pkg::AM_DIRECT;
  assign short_a = dmd_pkg::IO_SHORT_BASE + {2'h0, req.addr[5:0]};

  // Only power-on clears it, as a write outlives system reset
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      wr_cnt <= '0;
    end else begin
      wr_cnt <= eeprom_write_strobe ? wr_cnt + 20'h1 : '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_take;
    take |=> !req_ready ##1 (resp_valid && req_ready);
  endproperty
  a_take: assert property (p_take) else $error("access not two cycles");
  property p_resp_pulse;
    resp_valid |=> !resp_valid;
  endproperty
  a_resp_pulse: assert property (p_resp_pulse) else $error("resp_valid too long");
  property p_rf;
    dir && req.addr <= dmd_pkg::RF_LAST |=> !io_out.valid;
  endproperty
  a_rf: assert property (p_rf) else $error("RF access left core");
  property p_io;
    dir && req.addr inside {[16'h0020:16'h00FF]} |=> io_out.valid && {8'h00, io_out.addr} == $past(req.addr);
  endproperty
  a_io: assert property (p_io) else $error("I/O region not selected");
  property p_sram;
    dir && req.addr inside {[16'h0100:16'h40FF]} |=> !io_out.valid ##1 resp_valid;
  endproperty
  a_sram: assert property (p_sram) else $error("SRAM misrouted");
  property p_short;
    take && req.mode == dmd_pkg::AM_IO_SHORT |=> io_out.valid && io_out.addr == $past(short_a);
  endproperty
  a_short: assert property (p_short) else $error("short I/O addr");
  property p_arm_clear;
    ee_arm_set ##1 (!ee_arm_set && !ee_strobe_set)[*4] |-> eeprom_write_arm ##1 !eeprom_write_arm;
  endproperty
  a_arm_clear: assert property (p_arm_clear) else $error("arm bit life wrong");
  property p_strobe_arm;
    $rose(eeprom_write_strobe) |-> $past(eeprom_write_arm) && $past(ee_strobe_set);
  endproperty
  a_strobe_arm: assert property (p_strobe_arm) else $error("write unarmed");
  property p_wr_stall;
    $rose(eeprom_write_strobe) |-> cpu_stall ##1 cpu_stall ##1 !cpu_stall;
  endproperty
  a_wr_stall: assert property (p_wr_stall) else $error("write stall");
  property p_rd_stall;
    ee_read_trig && !eeprom_write_strobe && !cpu_stall |=> cpu_stall[*4] ##1 !cpu_stall;
  endproperty
  a_rd_stall: assert property (p_rd_stall) else $error("read stall");
  property p_strobe_len;
    $fell(eeprom_write_strobe) |-> wr_cnt == EE_WRITE_CYCLES + 1;
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("write time wrong");
  property p_boot;
    1'b1 |=> fetch_in_boot == ($past(pc) >= dmd_pkg::BOOT_START);
  endproperty
  a_boot: assert property (p_boot) else $error("boot flag");
endmodule

bind dmd_mem_decoder dmd_mem_decoder_checker #(
  .EE_WRITE_CYCLES(EE_WRITE_CYCLES)
) u_dmd_mem_decoder_checker (
  .clk, .arst_n, .por_n, .req, .req_ready, .resp_valid, .io_out, .pc, .fetch_in_boot,
  .ee_read_trig, .ee_arm_set, .ee_strobe_set, .eeprom_write_arm, .eeprom_write_strobe,
  .cpu_stall
);

// ---- dv/tb_dmd_mem_decoder.sv ----
/*
 * Self-checking bench of the decoder.
 * Assumes the I/O model on io_out and a short write time.
 */
`timescale 1ns/1ps
module tb_dmd_mem_decoder;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int     EE_CYC = 20;
  logic              clk, arst_n, por_n, req_ready, resp_valid, rf_we;
  logic              fetch_in_boot, pm_load_valid, pm_load_done, pm_wr_en, pm_wr_from_boot;
  logic              ee_read_trig, ee_arm_set, ee_strobe_set;
  logic              eeprom_write_arm, eeprom_write_strobe, cpu_stall;
  logic [4:0]        rf_idx;
  logic [7:0]        rf_wdata, resp_rdata, io_rdata, pm_load_data, ee_wdata, ee_rdata, rd, ioa;
  logic [11:0]       ee_addr;
  logic [15:0]       pc, fetch_word, pm_wr_addr, pm_wr_data;
  logic              iov;
  dmd_pkg::dmd_req_t req;
  dmd_pkg::dmd_io_t  io_out;
  int                num_errors = 0;
  int                checked = 0;

  dmd_mem_decoder #(.EE_WRITE_CYCLES(EE_CYC)) u_dmd_mem_decoder (
    .clk, .arst_n, .por_n, .req, .req_ready, .resp_valid, .resp_rdata, .rf_we, .rf_idx,
    .rf_wdata, .io_out, .io_rdata, .pc, .fetch_word, .fetch_in_boot, .pm_load_valid,
    .pm_load_done, .pm_load_data, .pm_wr_en, .pm_wr_addr, .pm_wr_data, .pm_wr_from_boot,
    .ee_addr, .ee_wdata, .ee_read_trig, .ee_arm_set, .ee_strobe_set, .ee_rdata,
    .eeprom_write_arm, .eeprom_write_strobe, .cpu_stall);
  dmd_io_regs_model u_dmd_io_regs_model (.clk, .io_out, .io_rdata);

  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic acc(input logic w, input dmd_pkg::dmd_mode_t m, input dmd_pkg::dmd_ptr_t p,
                     input logic [15:0] a, input logic [5:0] d, input logic [7:0] wd);
    for (int n = 0; n < 50 && req_ready !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    req <= '{1'b1, w, m, p, a, d, wd};
    @(posedge clk);
    req <= '0;
    #1;
    iov = io_out.valid;
    ioa = io_out.addr;
    check("busy", {15'h0000, req_ready}, 16'h0000);
    @(posedge clk);
    #1;
    check("resp", {15'h0000, resp_valid}, 16'h0001);
    rd = resp_rdata;
  endtask

  task automatic ldchk(input logic [15:0] a, input logic [7:0] exp);
    acc(1'b0, dmd_pkg::AM_DIRECT, dmd_pkg::PS_X, a, 6'h00, 8'h00);
    check("load", {8'h00, rd}, {8'h00, exp});
  endtask

  task automatic set_ptr(input logic [4:0] lo, input logic [15:0] v);
    @(posedge clk);
    rf_we <= 1'b1;
    rf_idx <= lo;
    rf_wdata <= v[7:0];
    @(posedge clk);
    rf_idx <= lo + 5'h01;
    rf_wdata <= v[15:8];
    @(posedge clk);
    rf_we <= 1'b0;
  endtask

  task automatic ee_write(input logic [11:0] a, input logic [7:0] d, input int gap,
                          input int rst, output int st, output int bz);
    st = 0;
    bz = 0;
    @(posedge clk);
    ee_addr <= a;
    ee_wdata <= d;
    ee_arm_set <= 1'b1;
    @(posedge clk);
    ee_arm_set <= 1'b0;
    repeat (gap - 1) @(posedge clk);
    ee_strobe_set <= 1'b1;
    @(posedge clk);
    ee_strobe_set <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      #1;
      st += int'(cpu_stall === 1'b1);
      bz += int'(eeprom_write_strobe === 1'b1);
      @(posedge clk);
      arst_n <= !(i >= rst && i < rst + 3);
    end
  endtask

  task automatic ee_read(input logic [11:0] a, input logic [7:0] exp);
    int st;
    st = 0;
    @(posedge clk);
    ee_addr <= a;
    ee_read_trig <= 1'b1;
    @(posedge clk);
    ee_read_trig <= 1'b0;
    repeat (10) begin
      #1;
      st += int'(cpu_stall === 1'b1);
      @(posedge clk);
    end
    check("rd_stall", st[15:0], 16'h0004);
    check("ee_data", {8'h00, ee_rdata}, {8'h00, exp});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regions();
    logic [15:0] tbl [8] = '{16'h001F, 16'h0020, 16'h005F, 16'h0060,
                             16'h00FF, 16'h0100, 16'h40FF, 16'h4100};
    logic        isio;
    for (int i = 0; i < 8; i++) begin
      isio = tbl[i] inside {[16'h0020:16'h00FF]};
      acc(1'b1, dmd_pkg::AM_DIRECT, dmd_pkg::PS_X, tbl[i], 6'h00, tbl[i][7:0] ^ 8'h5A);
      check("io_sel", {15'h0000, iov}, {15'h0000, isio});
      if (isio) check("io_addr", {8'h00, ioa}, {8'h00, tbl[i][7:0]});
      ldchk(tbl[i], tbl[i] > 16'h40FF ? 8'h00 : tbl[i][7:0] ^ 8'h5A);
    end
  endtask

  task automatic t_short_and_ptr();
    acc(1'b1, dmd_pkg::AM_IO_SHORT, dmd_pkg::PS_X, 16'h0020, 6'h00, 8'h6B);
    check("short", {7'h00, iov, ioa}, 16'h0140);
    ldchk(16'h0040, 8'h6B);
    set_ptr(dmd_pkg::PTR_Y_LO, 16'h0100);
    acc(1'b1, dmd_pkg::AM_DISP, dmd_pkg::PS_Y, 16'h0000, 6'h3F, 8'hC3);
    ldchk(16'h013F, 8'hC3);
    set_ptr(dmd_pkg::PTR_X_LO, 16'h01FF);
    acc(1'b1, dmd_pkg::AM_POSTINC, dmd_pkg::PS_X, 16'h0000, 6'h00, 8'hA1);
    ldchk(16'h01FF, 8'hA1);
    ldchk(16'h001A, 8'h00);
    ldchk(16'h001B, 8'h02);
    set_ptr(dmd_pkg::PTR_Z_LO, 16'h0300);
    acc(1'b1, dmd_pkg::AM_PREDEC, dmd_pkg::PS_Z, 16'h0000, 6'h00, 8'h7E);
    ldchk(16'h02FF, 8'h7E);
    ldchk(16'h001E, 8'hFF);
  endtask

  task automatic t_pm();
    logic [15:0] wa [3] = '{16'h0010, 16'hF000, 16'hF000};
    logic [15:0] wv [3] = '{16'hBEEF, 16'h55AA, 16'h1234};
    logic [15:0] zp [2] = '{16'h0021, 16'h0020};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      pm_wr_en <= 1'b1;
      pm_wr_addr <= wa[i];
      pm_wr_data <= wv[i];
      pm_wr_from_boot <= (i == 1);
      @(posedge clk);
      pm_wr_en <= 1'b0;
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      pc <= wa[i];
      repeat (2) @(posedge clk);
      #1;
      check("fetch", fetch_word, wv[i]);
      check("boot", {15'h0000, fetch_in_boot}, 16'(i));
      set_ptr(dmd_pkg::PTR_Z_LO, zp[i]);
      @(posedge clk);
      pm_load_valid <= 1'b1;
      @(posedge clk);
      pm_load_valid <= 1'b0;
      #1;
      check("pm_load", {7'h00, pm_load_done, pm_load_data},
            {8'h01, i ? wv[0][7:0] : wv[0][15:8]});
    end
  endtask

  task automatic t_ee();
    int st;
    int bz;
    ee_write(12'hFFF, 8'h3C, 3, 99, st, bz);
    check("wr_stall", st[15:0], 16'h0002);
    check("wr_busy", bz[15:0], 16'(EE_CYC + 1));
    ee_read(12'hFFF, 8'h3C);
    ee_write(12'hFFF, 8'h22, 6, 99, st, bz);
    check("late_strobe", bz[15:0], 16'h0000);
    ee_read(12'hFFF, 8'h3C);
    ee_write(12'h002, 8'h99, 1, 5, st, bz);
    check("rst_busy", bz[15:0], 16'(EE_CYC + 1));
    ee_read(12'h002, 8'h99);
  endtask

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    {clk, arst_n, por_n, rf_we, pm_load_valid, pm_wr_en, pm_wr_from_boot} = '0;
    {ee_read_trig, ee_arm_set, ee_strobe_set, rf_idx, rf_wdata, pc} = '0;
    {pm_wr_addr, pm_wr_data, ee_addr, ee_wdata} = '0;
    req = '0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    por_n <= 1'b1;
    t_regions();
    t_short_and_ptr();
    t_pm();
    t_ee();
    wrap_up();
  end

  // Whole run needs about 300 cycles
  initial begin
    #100000;
    num_errors++;
    wrap_up();
  end
endmodule
